// ===== hw/pocp_regs.vh
`ifndef POCP_REGS_VH
`define POCP_REGS_VH

// clock and timebase
`define POCP_CLK_PERIOD_NS 10
`define POCP_TICK_PERIOD_NS 10000
`define POCP_TICK_CYCLES (`POCP_TICK_PERIOD_NS / `POCP_CLK_PERIOD_NS)
`define POCP_TICK_US (`POCP_TICK_PERIOD_NS / 1000)

// register offsets
`define POCP_ADDR_DIS_CFG 8'h00
`define POCP_ADDR_CHG_CFG 8'h01
`define POCP_ADDR_FET_CTRL 8'h02
`define POCP_ADDR_STATUS 8'h03
`define POCP_ADDR_CLEAR 8'h04
`define POCP_ADDR_IRQ_EN 8'h05

// reset values
`define POCP_CFG_RESET 8'h00
`define POCP_FET_RESET 2'h0
`define POCP_STAT_RESET 5'h00

// writable bits of the configuration registers
`define POCP_DIS_CFG_MASK 8'h6F
`define POCP_CHG_CFG_MASK 8'h7F

// discharge configuration fields
`define POCP_DIS_OC_THR_HI 6
`define POCP_DIS_OC_THR_LO 5
`define POCP_SHORT_THR_HI 3
`define POCP_SHORT_THR_LO 2
`define POCP_DIS_OC_TMO_HI 1
`define POCP_DIS_OC_TMO_LO 0

// charge configuration fields
`define POCP_CHG_OC_THR_HI 6
`define POCP_CHG_OC_THR_LO 5
`define POCP_SHORT_LONG_BIT 4
`define POCP_CHG_DIV_BIT 3
`define POCP_DIS_DIV_BIT 2
`define POCP_CHG_OC_TMO_HI 1
`define POCP_CHG_OC_TMO_LO 0

// fet control fields
`define POCP_FET_CHG_BIT 0
`define POCP_FET_DIS_BIT 1

// status, clear and enable fields
`define POCP_ST_DIS_OC 0
`define POCP_ST_CHG_OC 1
`define POCP_ST_SHORT 2
`define POCP_ST_INT_TEMP 3
`define POCP_ST_EXT_TEMP 4
`define POCP_ST_WIDTH 5

// delays
`define POCP_DIS_OC_BASE_MS 160
`define POCP_CHG_OC_BASE_MS 80
`define POCP_SHORT_SHORT_US 190
`define POCP_SHORT_LONG_MS 10
`define POCP_DIS_DIV_SHIFT 6
`define POCP_CHG_DIV_SHIFT 5
`define POCP_DIS_OC_BASE_TICKS ((`POCP_DIS_OC_BASE_MS * 1000) / `POCP_TICK_US)
`define POCP_CHG_OC_BASE_TICKS ((`POCP_CHG_OC_BASE_MS * 1000) / `POCP_TICK_US)
`define POCP_SHORT_SHORT_TICKS ((`POCP_SHORT_SHORT_US + `POCP_TICK_US - 1) / `POCP_TICK_US)
`define POCP_SHORT_LONG_TICKS ((`POCP_SHORT_LONG_MS * 1000) / `POCP_TICK_US)
`define POCP_DLY_WIDTH 18

`endif

// ===== hw/pocp_timebase.v
`timescale 1ns/1ps
// free-running tick, one cycle high every CYCLES clocks
module pocp_timebase #(
  parameter CYCLES = 1000
) (
  input wire i_core_clk, // core clock
  input wire i_rst_n, // synchronous reset, active low
  output reg o_tick // one-cycle timebase pulse
);
  reg [15:0] count;

  // count up and emit a tick at wrap
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      count <= 16'h0000;
      o_tick <= 1'b0;
    end else if (count == CYCLES[15:0] - 16'h0001) begin
      count <= 16'h0000;
      o_tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      o_tick <= 1'b0;
    end
  end
endmodule

// ===== hw/pocp_qualify.v
`timescale 1ns/1ps
`include "pocp_regs.vh"
// persistence check: fires once the input has stood longer than the limit
module pocp_qualify #(
  parameter W = `POCP_DLY_WIDTH
) (
  input wire i_core_clk, // core clock
  input wire i_rst_n, // synchronous reset, active low
  input wire i_tick, // timebase pulse
  input wire i_cmp, // comparator output, high above threshold
  input wire [W-1:0] i_limit, // delay in ticks
  output reg o_fire // level, high while qualified
);
  reg [W-1:0] count;

  // count ticks while above threshold, restart when it drops
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      count <= {W{1'b0}};
      o_fire <= 1'b0;
    end else if (!i_cmp) begin
      count <= {W{1'b0}};
      o_fire <= 1'b0;
    end else begin
      if (i_tick && count <= i_limit) begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
      o_fire <= (count > i_limit);
    end
  end
endmodule

// ===== hw/pocp_top.v
`timescale 1ns/1ps
`include "pocp_regs.vh"
// Functional notes
// - power failure resets every register, fets off
// - responds to faults without host help
// - current fault only after threshold exceeded past delay
// - any current fault turns both fets off
// - all registers power up at zero
// - discharge overcurrent threshold from discharge bits 6:5
// - short threshold from discharge bits 3:2
// - charge overcurrent threshold from charge bits 6:5
// - discharge timeout from discharge bits 1:0
// - discharge divider bit divides timeout by 64
// - charge timeout from charge bits 1:0
// - charge divider bit divides timeout by 32
// - short long-delay bit picks 190us or 10ms
// - confirmed fault sets its status flag
// - protection clears both fet control bits
// - discharge fet off by protection or host
module pocp_top #(
  parameter TICK_CYCLES = `POCP_TICK_CYCLES,
  parameter AW = 8,
  parameter DW = 8
) (
  input wire i_core_clk, // core clock, 100 MHz
  input wire i_rst_n, // synchronous reset, active low
  input wire i_power_fail, // supply below power-on level
  input wire [AW-1:0] i_addr, // register address
  input wire [DW-1:0] i_wr_data, // register write data
  input wire i_wr_en, // write strobe
  input wire i_rd_en, // read strobe
  output reg [DW-1:0] o_rd_data, // read data, cycle after strobe
  input wire i_dis_oc_cmp, // discharge overcurrent comparator
  input wire i_short_cmp, // discharge short comparator
  input wire i_chg_oc_cmp, // charge overcurrent comparator
  input wire i_int_over_temp, // internal over-temperature
  input wire i_ext_over_temp, // external over-temperature
  output reg [1:0] o_dis_oc_threshold, // discharge oc level select
  output reg [1:0] o_short_threshold, // short level select
  output reg [1:0] o_chg_oc_threshold, // charge oc level select
  output reg o_charge_fet_gate, // charge fet gate on
  output reg o_discharge_fet_gate, // discharge fet gate on
  output reg o_irq // level interrupt
);
  // registers
  reg [DW-1:0] discharge_protection_config;
  reg [DW-1:0] charge_protection_config;
  reg charge_fet_control;
  reg discharge_fet_control;
  reg [`POCP_ST_WIDTH-1:0] status;
  reg [`POCP_ST_WIDTH-1:0] irq_enable;
  reg [`POCP_ST_WIDTH-1:0] next_status;
  reg [DW-1:0] next_rd_data;
  reg [`POCP_DLY_WIDTH-1:0] dis_oc_limit;
  reg [`POCP_DLY_WIDTH-1:0] chg_oc_limit;
  reg [`POCP_DLY_WIDTH-1:0] short_limit;
  reg next_chg_fet;
  reg next_dis_fet;

  wire tick;
  wire dis_oc_fire;
  wire chg_oc_fire;
  wire short_fire;
  wire live_n;
  wire current_fault;
  wire temp_fault;
  wire any_fault;
  wire wr_dis_cfg;
  wire wr_chg_cfg;
  wire wr_fet;
  wire wr_clear;
  wire wr_irq_en;
  wire [1:0] dis_oc_tmo;
  wire [1:0] chg_oc_tmo;
  wire dis_div;
  wire chg_div;
  wire short_long;
  wire [`POCP_ST_WIDTH-1:0] fault_events;

  // combined reset: pin or power failure
  assign live_n = i_rst_n & ~i_power_fail;

  // write decode
  assign wr_dis_cfg = i_wr_en && (i_addr == `POCP_ADDR_DIS_CFG);
  assign wr_chg_cfg = i_wr_en && (i_addr == `POCP_ADDR_CHG_CFG);
  assign wr_fet = i_wr_en && (i_addr == `POCP_ADDR_FET_CTRL);
  assign wr_clear = i_wr_en && (i_addr == `POCP_ADDR_CLEAR);
  assign wr_irq_en = i_wr_en && (i_addr == `POCP_ADDR_IRQ_EN);

  // configuration fields
  assign dis_oc_tmo = discharge_protection_config[`POCP_DIS_OC_TMO_HI:
                                                  `POCP_DIS_OC_TMO_LO];
  assign chg_oc_tmo = charge_protection_config[`POCP_CHG_OC_TMO_HI:
                                               `POCP_CHG_OC_TMO_LO];
  assign dis_div = charge_protection_config[`POCP_DIS_DIV_BIT];
  assign chg_div = charge_protection_config[`POCP_CHG_DIV_BIT];
  assign short_long = charge_protection_config[`POCP_SHORT_LONG_BIT];

  // fixed timebase for all delay counters
  pocp_timebase #(
    .CYCLES(TICK_CYCLES)
  ) u_timebase (
    .i_core_clk(i_core_clk),
    .i_rst_n(live_n),
    .o_tick(tick)
  );

  // discharge overcurrent timeout: base doubled per code, optional /64
  always @* begin
    dis_oc_limit = `POCP_DIS_OC_BASE_TICKS;
    dis_oc_limit = dis_oc_limit << dis_oc_tmo;
    if (dis_div) begin
      dis_oc_limit = dis_oc_limit >> `POCP_DIS_DIV_SHIFT;
    end
  end

  // charge overcurrent timeout: base doubled per code, optional /32
  always @* begin
    chg_oc_limit = `POCP_CHG_OC_BASE_TICKS;
    chg_oc_limit = chg_oc_limit << chg_oc_tmo;
    if (chg_div) begin
      chg_oc_limit = chg_oc_limit >> `POCP_CHG_DIV_SHIFT;
    end
  end

  // short-circuit persistence select
  always @* begin
    if (short_long) begin
      short_limit = `POCP_SHORT_LONG_TICKS;
    end else begin
      short_limit = `POCP_SHORT_SHORT_TICKS;
    end
  end

  // discharge overcurrent qualifier
  pocp_qualify #(
    .W(`POCP_DLY_WIDTH)
  ) u_dis_oc (
    .i_core_clk(i_core_clk),
    .i_rst_n(live_n),
    .i_tick(tick),
    .i_cmp(i_dis_oc_cmp),
    .i_limit(dis_oc_limit),
    .o_fire(dis_oc_fire)
  );

  // charge overcurrent qualifier
  pocp_qualify #(
    .W(`POCP_DLY_WIDTH)
  ) u_chg_oc (
    .i_core_clk(i_core_clk),
    .i_rst_n(live_n),
    .i_tick(tick),
    .i_cmp(i_chg_oc_cmp),
    .i_limit(chg_oc_limit),
    .o_fire(chg_oc_fire)
  );

  // discharge short-circuit qualifier
  pocp_qualify #(
    .W(`POCP_DLY_WIDTH)
  ) u_short (
    .i_core_clk(i_core_clk),
    .i_rst_n(live_n),
    .i_tick(tick),
    .i_cmp(i_short_cmp),
    .i_limit(short_limit),
    .o_fire(short_fire)
  );

  // fault summary; temperature faults act at once
  assign current_fault = dis_oc_fire | chg_oc_fire | short_fire;
  assign temp_fault = i_int_over_temp | i_ext_over_temp;
  assign any_fault = current_fault | temp_fault;

  // event vector in status layout
  assign fault_events = {i_ext_over_temp, i_int_over_temp, short_fire,
                         chg_oc_fire, dis_oc_fire};

  // configuration registers, reserved bits held at zero
  always @(posedge i_core_clk) begin
    if (!live_n) begin
      discharge_protection_config <= `POCP_CFG_RESET;
      charge_protection_config <= `POCP_CFG_RESET;
    end else begin
      if (wr_dis_cfg) begin
        discharge_protection_config <= i_wr_data & `POCP_DIS_CFG_MASK;
      end
      if (wr_chg_cfg) begin
        charge_protection_config <= i_wr_data & `POCP_CHG_CFG_MASK;
      end
    end
  end

  // fet control next values; protection beats a host write
  always @* begin
    next_chg_fet = charge_fet_control;
    next_dis_fet = discharge_fet_control;
    if (wr_fet) begin
      next_chg_fet = i_wr_data[`POCP_FET_CHG_BIT];
      next_dis_fet = i_wr_data[`POCP_FET_DIS_BIT];
    end
    if (any_fault) begin
      next_chg_fet = 1'b0;
      next_dis_fet = 1'b0;
    end
  end

  // fet control bits and gate drive
  always @(posedge i_core_clk) begin
    if (!live_n) begin
      charge_fet_control <= 1'b0;
      discharge_fet_control <= 1'b0;
      o_charge_fet_gate <= 1'b0;
      o_discharge_fet_gate <= 1'b0;
    end else begin
      charge_fet_control <= next_chg_fet;
      discharge_fet_control <= next_dis_fet;
      o_charge_fet_gate <= next_chg_fet;
      o_discharge_fet_gate <= next_dis_fet;
    end
  end

  // sticky status: set wins over a clear in the same cycle
  always @* begin
    next_status = status;
    if (wr_clear) begin
      next_status = status & ~i_wr_data[`POCP_ST_WIDTH-1:0];
    end
    next_status = next_status | fault_events;
  end

  // status and interrupt enable registers
  always @(posedge i_core_clk) begin
    if (!live_n) begin
      status <= `POCP_STAT_RESET;
      irq_enable <= `POCP_STAT_RESET;
      o_irq <= 1'b0;
    end else begin
      status <= next_status;
      if (wr_irq_en) begin
        irq_enable <= i_wr_data[`POCP_ST_WIDTH-1:0];
      end
      o_irq <= |(next_status & irq_enable);
    end
  end

  // threshold selects sent to the comparators
  always @(posedge i_core_clk) begin
    if (!live_n) begin
      o_dis_oc_threshold <= 2'h0;
      o_short_threshold <= 2'h0;
      o_chg_oc_threshold <= 2'h0;
    end else begin
      o_dis_oc_threshold <= discharge_protection_config[
        `POCP_DIS_OC_THR_HI:`POCP_DIS_OC_THR_LO];
      o_short_threshold <= discharge_protection_config[
        `POCP_SHORT_THR_HI:`POCP_SHORT_THR_LO];
      o_chg_oc_threshold <= charge_protection_config[
        `POCP_CHG_OC_THR_HI:`POCP_CHG_OC_THR_LO];
    end
  end

  // read mux; write-only and unmapped addresses read zero
  always @* begin
    next_rd_data = {DW{1'b0}};
    case (i_addr)
      `POCP_ADDR_DIS_CFG: begin
        next_rd_data = discharge_protection_config;
      end
      `POCP_ADDR_CHG_CFG: begin
        next_rd_data = charge_protection_config;
      end
      `POCP_ADDR_FET_CTRL: begin
        next_rd_data[`POCP_FET_CHG_BIT] = charge_fet_control;
        next_rd_data[`POCP_FET_DIS_BIT] = discharge_fet_control;
      end
      `POCP_ADDR_STATUS: begin
        next_rd_data[`POCP_ST_WIDTH-1:0] = status;
      end
      `POCP_ADDR_IRQ_EN: begin
        next_rd_data[`POCP_ST_WIDTH-1:0] = irq_enable;
      end
      default: begin
        next_rd_data = {DW{1'b0}};
      end
    endcase
  end

  // read data stands one cycle after the strobe only
  always @(posedge i_core_clk) begin
    if (!live_n) begin
      o_rd_data <= {DW{1'b0}};
    end else if (i_rd_en) begin
      o_rd_data <= next_rd_data;
    end else begin
      o_rd_data <= {DW{1'b0}};
    end
  end
endmodule

// ===== testbench/pocp_top_assertions.sv
`timescale 1ns/1ps
// pin-level checks of the protection block
module pocp_checker (
  input wire i_core_clk, // clock
  input wire i_rst_n, // reset
  input wire i_power_fail, // supply loss
  input wire [7:0] i_addr, // address
  input wire [7:0] i_wr_data, // write data
  input wire i_wr_en, // write strobe
  input wire i_rd_en, // read strobe
  input wire [7:0] o_rd_data, // read data
  input wire i_dis_oc_cmp, // dis oc
  input wire i_short_cmp, // short
  input wire i_chg_oc_cmp, // chg oc
  input wire i_int_over_temp, // int temp
  input wire i_ext_over_temp, // ext temp
  input wire [1:0] o_dis_oc_threshold, // dis oc level
  input wire [1:0] o_short_threshold, // short level
  input wire [1:0] o_chg_oc_threshold, // chg oc level
  input wire o_charge_fet_gate, // charge gate
  input wire o_discharge_fet_gate, // discharge gate
  input wire o_irq // interrupt
);
  // fault sources other than the short comparator
  wire others = i_dis_oc_cmp | i_chg_oc_cmp | i_int_over_temp |
    i_ext_over_temp;
  wire any_ev = others | i_short_cmp;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n || i_power_fail);
  rd_idle_a: assert property (!$past(i_rd_en) |-> o_rd_data == 8'h00)
    else $error("read data not idle");
  fet_wr_a: assert property (
    i_wr_en && i_addr == 8'h02 && !any_ev && !$past(any_ev) |=>
    {o_discharge_fet_gate, o_charge_fet_gate} == $past(i_wr_data[1:0]))
    else $error("fet write not applied");
  dis_thr_a: assert property (i_wr_en && i_addr == 8'h00 |=> ##1
    o_dis_oc_threshold == $past(i_wr_data[6:5], 2))
    else $error("dis oc level wrong");
  short_thr_a: assert property (i_wr_en && i_addr == 8'h00 |=> ##1
    o_short_threshold == $past(i_wr_data[3:2], 2))
    else $error("short level wrong");
  chg_thr_a: assert property (i_wr_en && i_addr == 8'h01 |=> ##1
    o_chg_oc_threshold == $past(i_wr_data[6:5], 2))
    else $error("chg oc level wrong");
  temp_off_a: assert property (i_int_over_temp || i_ext_over_temp
    |=> !o_charge_fet_gate && !o_discharge_fet_gate)
    else $error("temp did not cut fets");
  short_min_a: assert property ($rose(i_short_cmp) && !others &&
    o_discharge_fet_gate && !i_wr_en |=> o_discharge_fet_gate [*8])
    else $error("short cut too early");
  fet_pair_a: assert property (
    $fell(o_discharge_fet_gate) && !$past(i_wr_en) |-> !o_charge_fet_gate)
    else $error("charge fet left on");
  irq_hold_a: assert property (o_irq &&
    !(i_wr_en && (i_addr == 8'h04 || i_addr == 8'h05)) |=> o_irq)
    else $error("irq dropped alone");
endmodule

bind pocp_top pocp_checker u_chk (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_power_fail(i_power_fail), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .o_rd_data(o_rd_data), .i_dis_oc_cmp(i_dis_oc_cmp),
  .i_short_cmp(i_short_cmp), .i_chg_oc_cmp(i_chg_oc_cmp),
  .i_int_over_temp(i_int_over_temp), .i_ext_over_temp(i_ext_over_temp),
  .o_dis_oc_threshold(o_dis_oc_threshold),
  .o_short_threshold(o_short_threshold),
  .o_chg_oc_threshold(o_chg_oc_threshold),
  .o_charge_fet_gate(o_charge_fet_gate),
  .o_discharge_fet_gate(o_discharge_fet_gate), .o_irq(o_irq));

// ===== testbench/pocp_host.sv
`timescale 1ns/1ps
// host side of the register port
module pocp_host (
  input wire i_core_clk, // clock
  input wire [7:0] i_rd_data, // read data
  output reg [7:0] o_addr = 8'h00, // address
  output reg [7:0] o_wr_data = 8'h00, // write data
  output reg o_wr_en = 1'b0, // write strobe
  output reg o_rd_en = 1'b0 // read strobe
);
  // one-cycle write, then spoil the data lines
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_core_clk);
      o_addr <= a;
      o_wr_data <= d;
      o_wr_en <= 1'b1;
      @(posedge i_core_clk);
      o_wr_en <= 1'b0;
      o_wr_data <= ~d;
    end
  endtask
  // one-cycle read, data taken in the answer cycle
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge i_core_clk);
      o_addr <= a;
      o_rd_en <= 1'b1;
      @(posedge i_core_clk);
      o_rd_en <= 1'b0;
      o_addr <= ~a;
      #1 d = i_rd_data;
    end
  endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam T = 2;
  reg i_core_clk = 0, i_rst_n = 0, i_power_fail = 0;
  reg [4:0] ev = 0; // ext temp, int temp, short, chg oc, dis oc
  reg [7:0] v, k;
  wire [7:0] a, wd, rdd;
  wire we, re, cg, dg, irq;
  wire [1:0] dt, st, ct;
  integer n_errors = 0, num_checks = 0, n;
  // clock
  initial forever #5 i_core_clk = ~i_core_clk;
  pocp_top #(.TICK_CYCLES(T)) dut (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_power_fail(i_power_fail), .i_addr(a),
    .i_wr_data(wd), .i_wr_en(we), .i_rd_en(re), .o_rd_data(rdd),
    .i_dis_oc_cmp(ev[0]), .i_chg_oc_cmp(ev[1]), .i_short_cmp(ev[2]),
    .i_int_over_temp(ev[3]), .i_ext_over_temp(ev[4]),
    .o_dis_oc_threshold(dt), .o_short_threshold(st),
    .o_chg_oc_threshold(ct), .o_charge_fet_gate(cg),
    .o_discharge_fet_gate(dg), .o_irq(irq));
  pocp_host host (.i_core_clk(i_core_clk), .i_rd_data(rdd), .o_addr(a),
    .o_wr_data(wd), .o_wr_en(we), .o_rd_en(re));
  // compare and count
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("Error %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task rc(input [7:0] ad, input [7:0] e, input string nm);
    begin
      host.rd(ad, v);
      chk(nm, v, e);
    end
  endtask
  // raise one source, time the cut, then clear it
  task fault(input integer s, input integer lim);
    begin
      host.wr(8'h02, 8'h03);
      host.wr(8'h05, 8'h01 << s);
      @(posedge i_core_clk) ev[s] <= 1'b1;
      n = 0;
      do begin
        @(posedge i_core_clk);
        #1 n = n + 1;
      end while (dg !== 1'b0 && n < 40000);
      chk("delay", n >= lim * T && n <= (lim + 2) * T + 3, 1);
      chk("chg_gate", cg, 0);
      chk("irq_on", irq, 1);
      rc(8'h03, 8'h01 << s, "status");
      host.wr(8'h02, 8'h03);
      rc(8'h02, 8'h00, "fet_bits");
      @(posedge i_core_clk) ev[s] <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      rc(8'h03, 8'h01 << s, "sticky");
      host.wr(8'h04, 8'h1F);
      rc(8'h03, 8'h00, "cleared");
      chk("irq_off", irq, 0);
      $display("fault test %0d done", s);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // watchdog
  initial begin
    #700000;
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    rc(8'h00, 8'h00, "dis_cfg_rst");
    rc(8'h01, 8'h00, "chg_cfg_rst");
    rc(8'h02, 8'h00, "fet_rst");
    rc(8'h03, 8'h00, "stat_rst");
    chk("thr_rst", {dt, st, ct, cg, dg}, 0);
    for (k = 0; k < 4; k = k + 1) begin
      host.wr(8'h00, k * 8'h24);
      host.wr(8'h01, k * 8'h20);
      rc(8'h00, k * 8'h24, "dis_cfg");
      chk("thr", {dt, st, ct}, k * 6'h15);
    end
    host.wr(8'h00, 8'hFF);
    host.wr(8'h01, 8'hFF);
    rc(8'h00, 8'h6F, "dis_mask");
    rc(8'h01, 8'h7F, "chg_mask");
    rc(8'h09, 8'h00, "unmapped");
    $display("config test done");
    for (k = 0; k < 4; k = k + 1) begin
      host.wr(8'h00, k);
      host.wr(8'h01, 8'h0C | k);
      fault(0, 250 << k);
      fault(1, 250 << k);
    end
    host.wr(8'h01, 8'h00);
    fault(1, 8000);
    host.wr(8'h01, 8'h10);
    fault(2, 1000);
    host.wr(8'h01, 8'h00);
    @(posedge i_core_clk) ev[2] <= 1'b1;
    repeat (15 * T) @(posedge i_core_clk);
    ev[2] <= 1'b0;
    rc(8'h03, 8'h00, "no_short");
    fault(2, 19);
    fault(3, 0);
    fault(4, 0);
    host.wr(8'h02, 8'h03);
    host.wr(8'h02, 8'h01);
    #1 chk("dis_off", {dg, cg}, 2'b01);
    host.wr(8'h00, 8'h21);
    @(posedge i_core_clk) i_power_fail <= 1'b1;
    @(posedge i_core_clk) i_power_fail <= 1'b0;
    #1 chk("pf_gates", {dg, cg}, 0);
    rc(8'h00, 8'h00, "pf_cfg");
    rc(8'h02, 8'h00, "pf_fet");
    $display("host and power test done");
    close_out;
  end
endmodule
